// ==== bench/pif_monitor.sv ====
// checker: bus timing, read-back zeros and request gating at the ports
`timescale 1ns/1ns
module pif_monitor
    import pif_pkg::*;
#(
    parameter int unsigned ADDR_W = PIF_ADDR_W,
    parameter int unsigned DATA_W = PIF_DATA_W
)
(
    input wire logic              clk,
    input wire logic              sys_rst,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic [7:0]        rx_data,
    input wire logic              rx_data_read,
    input wire logic [7:0]        tx_data,
    input wire logic              tx_data_write,
    input wire logic              periph_irq,
    input wire logic              irq
);
    logic       per_en;
    wire        rd_done = psel && penable && pready && !pwrite;
    wire        wr_done = psel && penable && pready && pwrite;
    wire  [7:0] wbyte   = pwdata[7:0];
    // peripheral enable shadow
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            per_en <= 1'b0;
        else if (wr_done && paddr == PIF_OFF_CORE_CTRL)
            per_en <= pwdata[PIF_BIT_PER_EN];
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_flags_one_zero:
        assert property (rd_done && paddr == PIF_OFF_FLAGS_ONE |-> !prdata[7])
        else $error("flags one bit 7 set");
    a_flags_two_zero:
        assert property (rd_done && paddr == PIF_OFF_FLAGS_TWO
            |-> prdata[3:0] == 4'h0)
        else $error("flags two low bits set");
    a_upper_zero:
        assert property (pready |-> prdata[DATA_W-1:8] == '0)
        else $error("upper data set");
    a_ready_timing:
        assert property (psel && $rose(penable) |=> pready ##1 !pready)
        else $error("ready timing wrong");
    a_err_code:
        assert property (pready && paddr[1:0] == 2'b00
            |-> pslverr == (paddr > PIF_OFF_IRQ_MASK))
        else $error("error response wrong");
    a_rx_read_pulse:
        assert property (rd_done && paddr == PIF_OFF_RX_DATA
            |=> rx_data_read ##1 !rx_data_read)
        else $error("rx read pulse wrong");
    a_rx_data_path:
        assert property (rd_done && paddr == PIF_OFF_RX_DATA
            |-> prdata[7:0] == $past(rx_data))
        else $error("rx byte wrong");
    a_tx_write_pulse:
        assert property (wr_done && paddr == PIF_OFF_TX_DATA |=> tx_data_write
            ##1 (!tx_data_write && tx_data == $past(wbyte, 2)))
        else $error("transmit write wrong");
    a_irq_gate:
        assert property (!$past(per_en) && !$past(per_en, 2) |-> !periph_irq)
        else $error("request while disabled");
    a_quiet_release:
        assert property ($fell(sys_rst) |-> !periph_irq && !irq && !pready)
        else $error("outputs busy after reset");
    c_rx_read: cover property (rd_done && paddr == PIF_OFF_RX_DATA);
    c_periph_irq: cover property ($rose(periph_irq));
    c_bus_err: cover property (pready && pslverr);
endmodule : pif_monitor

bind pif_peripheral_flags pif_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W))
    pif_monitor_inst (.*);

// ==== bench/pif_periph_model.sv ====
// serial port buffer model on the far side of the flag block
`timescale 1ns/1ns
module pif_periph_model
    import pif_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       rx_push,
    input  wire logic [7:0] rx_byte,
    input  wire logic [7:0] tx_delay,
    input  wire logic       rx_data_read,
    input  wire logic       tx_data_write,
    output logic            rx_buffer_full,
    output logic      [7:0] rx_data,
    output logic            tx_buffer_empty
);
    logic [7:0] tx_cnt;
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            rx_buffer_full  <= 1'b0;
            rx_data         <= 8'ha5;
            tx_buffer_empty <= 1'b1;
            tx_cnt          <= 8'h00;
        end
        else
        begin
            if (rx_push)
            begin
                rx_buffer_full <= 1'b1;
                rx_data        <= rx_byte;
            end
            else if (rx_data_read)
            begin
                rx_buffer_full <= 1'b0;
                rx_data        <= ~rx_data;
            end
            if (tx_data_write)
            begin
                tx_buffer_empty <= 1'b0;
                tx_cnt          <= tx_delay;
            end
            else if (!tx_buffer_empty && tx_cnt == 8'h00)
                tx_buffer_empty <= 1'b1;
            else if (!tx_buffer_empty)
                tx_cnt <= tx_cnt - 8'h01;
        end
    end
endmodule : pif_periph_model

// ==== bench/tb.sv ====
// testbench: register map, event flags, serial buffers and interrupts
`timescale 1ns/1ns
module tb;
    import pif_pkg::*;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rx_push = 1'b0;
    logic [7:0]  paddr = 8'h00, ev = 8'h00, rx_byte = 8'h00;
    logic [7:0]  tx_delay = 8'h00, m, rx_data, tx_data;
    logic [31:0] pwdata = 32'h0, prdata, rdv;
    logic [1:0]  ccp_mode = 2'h0, cmp = 2'h0;
    logic        pready, pslverr, errv, rx_data_read, tx_data_write;
    logic        rx_buffer_full, tx_buffer_empty, periph_irq, irq;
    int          bad_count = 0, n_checks = 0;
    always #20 clk = ~clk;
    pif_peripheral_flags pif_peripheral_flags_inst (.*,
        .adc_done(ev[0]), .ssp_done(ev[1]), .ccp_capture(ev[2]),
        .ccp_compare_match(ev[3]), .period_match(ev[4]),
        .timer_overflow(ev[5]), .osc_fail(ev[6]), .nv_write_done(ev[7]),
        .comparator_one_output(cmp[0]), .comparator_two_output(cmp[1]));
    pif_periph_model pif_periph_model_inst (.*);
    task automatic chk_val(input string nm, input logic [31:0] e,
                           input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_val
    task automatic chk_bit(input string nm, input logic e, input logic g);
        chk_val(nm, {31'h0, e}, {31'h0, g});
    endtask : chk_bit
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 40);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk_bit("pready", 1'b1, pready);
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk_val($sformatf("register %h", a), e, rdv);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic pulse(input int i);
        @(posedge clk);
        ev[i] <= 1'b1;
        @(posedge clk);
        ev[i] <= 1'b0;
        repeat ($urandom_range(4, 1)) @(posedge clk);
    endtask : pulse
    function automatic logic [7:0] ev_mask(input int i);
        case (i)
            0: return 8'h40;
            1: return 8'h08;
            2, 3: return 8'h04;
            4: return 8'h02;
            5: return 8'h01;
            6: return 8'h80;
            default: return 8'h10;
        endcase
    endfunction : ev_mask
    // one event, one ccp mode, enables off
    task automatic ev_case(input int i, input int k);
        logic [7:0] a;
        a = (i < 6) ? PIF_OFF_FLAGS_ONE : PIF_OFF_FLAGS_TWO;
        m = ev_mask(i) | ((i < 6) ? 8'h10 : 8'h00);
        if ((i == 2 && k != 1) || (i == 3 && k != 2))
            m = 8'h10;
        ccp_mode <= k[1:0];
        pulse(i);
        rd(a, {24'h0, m});
        repeat ($urandom_range(9, 1)) @(posedge clk);
        rd(a, {24'h0, m});
        wr(a, 32'h0);
    endtask : ev_case
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : complete_run
    initial
    begin
        #2000000;
        bad_count++;
        complete_run();
    end
    initial
    begin
        void'($urandom(32'h75bdaad5));
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        for (int a = 0; a <= 32; a += 4)
            rd(a[7:0], (a == 0) ? 32'h10 : (a == 20) ? {24'h0, rx_data} : 0);
        apb(1'b0, 8'h24, 32'h0);
        chk_bit("pslverr", 1'b1, errv);
        chk_val("error data", 32'h0, rdv);
        wr(PIF_OFF_FLAGS_ONE, 32'hffff_ffff);
        wr(PIF_OFF_FLAGS_TWO, 32'hffff_ffff);
        wr(PIF_OFF_EN_TWO, 32'hffff_ffff);
        rd(PIF_OFF_FLAGS_ONE, 32'h5f);
        rd(PIF_OFF_FLAGS_TWO, 32'hf0);
        rd(PIF_OFF_EN_TWO, 32'hf0);
        wr(PIF_OFF_FLAGS_ONE, 32'h0);
        wr(PIF_OFF_FLAGS_TWO, 32'h0);
        wr(PIF_OFF_EN_TWO, 32'h0);
        rd(PIF_OFF_FLAGS_ONE, 32'h10);
        rd(PIF_OFF_FLAGS_TWO, 32'h0);
        $display("test registers done");
        for (int i = 0; i < 8; i++)
            for (int k = 0; k < 4; k++)
                if (i == 2 || i == 3 || k == 0)
                    ev_case(i, k);
        for (int j = 0; j < 2; j++)
        begin
            @(posedge clk);
            cmp[j] <= ~cmp[j];
            repeat (3) @(posedge clk);
            rd(PIF_OFF_FLAGS_TWO, j ? 32'h40 : 32'h20);
            wr(PIF_OFF_FLAGS_TWO, 32'h0);
        end
        $display("test events done");
        for (int r = 0; r < 2; r++)
        begin
            rx_byte <= 8'($urandom);
            tx_delay <= (r == 0) ? 8'd40 : 8'd0;
            rx_push <= 1'b1;
            @(posedge clk);
            rx_push <= 1'b0;
            rd(PIF_OFF_FLAGS_ONE, 32'h30);
            rd(PIF_OFF_RX_DATA, {24'h0, rx_byte});
            rd(PIF_OFF_FLAGS_ONE, 32'h10);
            wr(PIF_OFF_TX_DATA, {24'h0, ~rx_byte});
            repeat (2) @(posedge clk);
            chk_val("tx_data", {24'h0, ~rx_byte}, {24'h0, tx_data});
            if (r == 0)
                rd(PIF_OFF_FLAGS_ONE, 32'h0);
            repeat (60) @(posedge clk);
            rd(PIF_OFF_FLAGS_ONE, 32'h10);
        end
        $display("test serial done");
        wr(PIF_OFF_FLAGS_ONE, 32'h0);
        wr(PIF_OFF_EN_ONE, 32'h40);
        wr(PIF_OFF_CORE_CTRL, 32'h40);
        chk_bit("periph_irq", 1'b0, periph_irq);
        pulse(0);
        repeat (3) @(posedge clk);
        chk_bit("periph_irq", 1'b1, periph_irq);
        chk_bit("irq", 1'b0, irq);
        wr(PIF_OFF_IRQ_MASK, 32'h1);
        repeat (2) @(posedge clk);
        chk_bit("irq", 1'b1, irq);
        wr(PIF_OFF_CORE_CTRL, 32'h0);
        repeat (2) @(posedge clk);
        chk_bit("periph_irq", 1'b0, periph_irq);
        rd(PIF_OFF_IRQ_STATUS, 32'h3);
        wr(PIF_OFF_IRQ_STATUS, 32'h3);
        repeat (2) @(posedge clk);
        chk_bit("irq", 1'b0, irq);
        rd(PIF_OFF_IRQ_STATUS, 32'h0);
        $display("test interrupts done");
        complete_run();
    end
endmodule : tb

// ==== core/pif_change_detect.sv ====
// change detector: one-cycle pulse when a level input toggles
`timescale 1ns/1ns
module pif_change_detect
    import pif_pkg::*;
#(
    parameter int unsigned WIDTH = 2
)
(
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] change
);

    logic [WIDTH-1:0] last_level;
    logic             primed;

    // first sample after reset only loads the history
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            last_level <= '0;
            primed     <= 1'b0;
            change     <= '0;
        end
        else
        begin
            last_level <= level;
            primed     <= 1'b1;
            change     <= primed ? (level ^ last_level) : '0;
        end
    end

endmodule : pif_change_detect

// ==== core/pif_flag_bank.sv ====
// sticky flag bank: hardware set, software write or write-one-clear
`timescale 1ns/1ns
module pif_flag_bank
    import pif_pkg::*;
#(
    parameter int unsigned      WIDTH      = 8,
    parameter logic [WIDTH-1:0] WRITE_MASK = '1,
    parameter bit               ONE_CLEARS = 1'b0
)
(
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] set_vec,
    input  wire logic             wr_en,
    input  wire logic [WIDTH-1:0] wr_data,
    output logic      [WIDTH-1:0] flags
);

    logic [WIDTH-1:0] written;
    logic [WIDTH-1:0] w1c_value;
    logic [WIDTH-1:0] sw_value;
    logic [WIDTH-1:0] next_flags;

    assign written   = (flags & ~WRITE_MASK) | (wr_data & WRITE_MASK);
    assign w1c_value = flags & ~(wr_data & WRITE_MASK);
    assign sw_value  = !wr_en ? flags : (ONE_CLEARS ? w1c_value : written);
    // a set in the clearing cycle is kept
    assign next_flags = (sw_value | set_vec) & WRITE_MASK;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            flags <= '0;
        else
            flags <= next_flags;
    end

endmodule : pif_flag_bank

// ==== core/pif_peripheral_flags.sv ====
// peripheral interrupt flag registers with apb access and request output
//
// Operation
// - first register bit 7, second register bits 3-0 read as zero
// - converter-done flag, bit 6, sets on conversion end, sticky
// - receive-full flag, bit 5, follows buffer; drops on data read
// - transmit-empty flag, bit 4, follows buffer; drops on data write
// - sync-serial-done flag, bit 3, sets on transfer end, sticky
// - capture mode: bit 2 sets on timer capture, sticky
// - compare mode: bit 2 sets on compare match; unused in pwm mode
// - period-match flag, bit 1, sets on period match, sticky
// - overflow flag, bit 0, sets on timer overflow, sticky
// - flags set regardless of individual or global enables
// - oscillator-fail flag, second bit 7, sets on clock failover
// - second comparator flag, bit 6, sets on output change
// - first comparator flag, bit 5, sets on output change
// - nonvolatile-write flag, bit 4, sets on write completion
// - requests pass only with peripheral enable and own enable set
`timescale 1ns/1ns
module pif_peripheral_flags
    import pif_pkg::*;
#(
    parameter int unsigned ADDR_W = PIF_ADDR_W,
    parameter int unsigned DATA_W = PIF_DATA_W
)
(
    input  wire logic              clk,
    input  wire logic              sys_rst,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    // peripheral events, one-cycle pulses, and the ccp mode level
    input  wire logic              adc_done,
    input  wire logic              ssp_done,
    input  wire logic [1:0]        ccp_mode,
    input  wire logic              ccp_capture,
    input  wire logic              ccp_compare_match,
    input  wire logic              period_match,
    input  wire logic              timer_overflow,
    input  wire logic              osc_fail,
    input  wire logic              nv_write_done,
    // comparator levels
    input  wire logic              comparator_one_output,
    input  wire logic              comparator_two_output,
    // serial port buffers
    input  wire logic              rx_buffer_full,
    input  wire logic [7:0]        rx_data,
    output logic                   rx_data_read,
    input  wire logic              tx_buffer_empty,
    output logic      [7:0]        tx_data,
    output logic                   tx_data_write,
    // interrupt outputs
    output logic                   periph_irq,
    output logic                   irq
);

    // zero-extends a register byte onto the bus
    function automatic logic [DATA_W-1:0] pif_word(
        input logic [PIF_REG_W-1:0] value
    );
        pif_word = {{(DATA_W - PIF_REG_W){1'b0}}, value};
    endfunction : pif_word

    // true when the bus address hits a given register
    function automatic logic pif_hit(
        input logic [ADDR_W-1:0] addr,
        input logic [7:0]        offset
    );
        pif_hit = (addr == ADDR_W'(offset));
    endfunction : pif_hit

    // bus phases
    logic                 access;
    logic                 done;
    logic                 wr_done;
    logic                 rd_done;
    logic                 next_pready;

    // address decode
    logic                 hit_flags_one;
    logic                 hit_flags_two;
    logic                 hit_en_one;
    logic                 hit_en_two;
    logic                 hit_core_ctrl;
    logic                 hit_rx_data;
    logic                 hit_tx_data;
    logic                 hit_irq_status;
    logic                 hit_irq_mask;
    logic                 mapped;

    // software-visible state
    logic [PIF_REG_W-1:0] enable_one;
    logic [PIF_REG_W-1:0] enable_two;
    logic [PIF_REG_W-1:0] core_interrupt_control;
    logic [PIF_IRQ_W-1:0] irq_mask;
    logic [PIF_IRQ_W-1:0] irq_status;

    // flag storage and views
    logic [PIF_REG_W-1:0] sticky_one;
    logic [PIF_REG_W-1:0] sticky_two;
    logic [PIF_REG_W-1:0] set_one;
    logic [PIF_REG_W-1:0] set_two;
    logic [PIF_REG_W-1:0] peripheral_flags_one;
    logic [PIF_REG_W-1:0] peripheral_flags_two;
    logic [PIF_REG_W-1:0] wr_byte;
    logic                 receive_full_flag;
    logic                 transmit_empty_flag;
    logic                 rx_consumed;
    logic                 tx_loaded;
    logic                 next_rx_consumed;
    logic                 next_tx_loaded;

    // event conditioning
    logic                 ccp_hit;
    logic [1:0]           cmp_levels;
    logic [1:0]           cmp_change;

    // request and interrupt
    logic                 per_en;
    logic                 next_periph_irq;
    logic                 req_rise;
    logic                 bus_err_event;
    logic [PIF_IRQ_W-1:0] irq_set;
    logic [DATA_W-1:0]    rd_value;

    assign access      = psel && penable;
    assign done        = access && pready;
    assign wr_done     = done && pwrite;
    assign rd_done     = done && !pwrite;
    // one wait state, answer one cycle into the access phase
    assign next_pready = access && !pready;

    assign hit_flags_one  = pif_hit(paddr, PIF_OFF_FLAGS_ONE);
    assign hit_flags_two  = pif_hit(paddr, PIF_OFF_FLAGS_TWO);
    assign hit_en_one     = pif_hit(paddr, PIF_OFF_EN_ONE);
    assign hit_en_two     = pif_hit(paddr, PIF_OFF_EN_TWO);
    assign hit_core_ctrl  = pif_hit(paddr, PIF_OFF_CORE_CTRL);
    assign hit_rx_data    = pif_hit(paddr, PIF_OFF_RX_DATA);
    assign hit_tx_data    = pif_hit(paddr, PIF_OFF_TX_DATA);
    assign hit_irq_status = pif_hit(paddr, PIF_OFF_IRQ_STATUS);
    assign hit_irq_mask   = pif_hit(paddr, PIF_OFF_IRQ_MASK);
    assign mapped = hit_flags_one || hit_flags_two || hit_en_one
                 || hit_en_two || hit_core_ctrl || hit_rx_data
                 || hit_tx_data || hit_irq_status || hit_irq_mask;

    assign wr_byte = pwdata[PIF_REG_W-1:0];

    // capture and compare share one flag; pwm and off leave it alone
    assign ccp_hit = ((ccp_mode == PIF_CCP_CAPTURE) && ccp_capture)
                  || ((ccp_mode == PIF_CCP_COMPARE)
                      && ccp_compare_match);

    assign cmp_levels = {comparator_two_output, comparator_one_output};

    // comparator toggles become one-cycle events
    pif_change_detect #(
        .WIDTH (2)
    ) u_cmp_change (
        .clk     (clk),
        .sys_rst (sys_rst),
        .level   (cmp_levels),
        .change  (cmp_change)
    );

    // events feed the flags with no enable in the path
    always_comb
    begin
        set_one               = '0;
        set_one[PIF_BIT_ADC]  = adc_done;
        set_one[PIF_BIT_SSP]  = ssp_done;
        set_one[PIF_BIT_CCP]  = ccp_hit;
        set_one[PIF_BIT_PRD]  = period_match;
        set_one[PIF_BIT_OVF]  = timer_overflow;
    end

    always_comb
    begin
        set_two               = '0;
        set_two[PIF_BIT_OSC]  = osc_fail;
        set_two[PIF_BIT_CMP2] = cmp_change[1];
        set_two[PIF_BIT_CMP1] = cmp_change[0];
        set_two[PIF_BIT_NVW]  = nv_write_done;
    end

    // sticky flags of the first register; buffer bits are not stored here
    pif_flag_bank #(
        .WIDTH      (PIF_REG_W),
        .WRITE_MASK (PIF_WR_ONE),
        .ONE_CLEARS (1'b0)
    ) u_flags_one (
        .clk     (clk),
        .sys_rst (sys_rst),
        .set_vec (set_one),
        .wr_en   (wr_done && hit_flags_one),
        .wr_data (wr_byte),
        .flags   (sticky_one)
    );

    // sticky flags of the second register
    pif_flag_bank #(
        .WIDTH      (PIF_REG_W),
        .WRITE_MASK (PIF_IMPL_TWO),
        .ONE_CLEARS (1'b0)
    ) u_flags_two (
        .clk     (clk),
        .sys_rst (sys_rst),
        .set_vec (set_two),
        .wr_en   (wr_done && hit_flags_two),
        .wr_data (wr_byte),
        .flags   (sticky_two)
    );

    // receive buffer counts as drained once its data has been read
    assign next_rx_consumed = rx_buffer_full
                           && (rx_consumed || (rd_done && hit_rx_data));
    // transmit buffer counts as filled once its data has been written
    assign next_tx_loaded   = tx_buffer_empty
                           && (tx_loaded || (wr_done && hit_tx_data));

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            rx_consumed       <= 1'b0;
            receive_full_flag <= 1'b0;
        end
        else
        begin
            rx_consumed       <= next_rx_consumed;
            receive_full_flag <= rx_buffer_full && !next_rx_consumed;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            tx_loaded           <= 1'b0;
            transmit_empty_flag <= 1'b0;
        end
        else
        begin
            tx_loaded           <= next_tx_loaded;
            transmit_empty_flag <= tx_buffer_empty && !next_tx_loaded;
        end
    end

    // strobes and data towards the serial port
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            rx_data_read  <= 1'b0;
            tx_data_write <= 1'b0;
            tx_data       <= PIF_RST_REG;
        end
        else
        begin
            rx_data_read  <= rd_done && hit_rx_data;
            tx_data_write <= wr_done && hit_tx_data;
            if (wr_done && hit_tx_data)
                tx_data <= wr_byte;
        end
    end

    // unimplemented bits forced low on every view
    assign peripheral_flags_one = (sticky_one
        | (PIF_REG_W'(receive_full_flag) << PIF_BIT_RX)
        | (PIF_REG_W'(transmit_empty_flag) << PIF_BIT_TX))
        & PIF_IMPL_ONE;
    assign peripheral_flags_two = sticky_two & PIF_IMPL_TWO;

    // enable and control registers
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            enable_one             <= PIF_RST_REG;
            enable_two             <= PIF_RST_REG;
            core_interrupt_control <= PIF_RST_REG;
        end
        else if (wr_done)
        begin
            if (hit_en_one)
                enable_one <= wr_byte & PIF_IMPL_ONE;
            if (hit_en_two)
                enable_two <= wr_byte & PIF_IMPL_TWO;
            if (hit_core_ctrl)
                core_interrupt_control <= wr_byte & PIF_CTRL_MASK;
        end
    end

    assign per_en = core_interrupt_control[PIF_BIT_PER_EN];

    // peripheral request: any enabled flag, behind the peripheral enable
    assign next_periph_irq = per_en
        && (|((peripheral_flags_one & enable_one)
            | (peripheral_flags_two & enable_two)));

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            periph_irq <= 1'b0;
        else
            periph_irq <= next_periph_irq;
    end

    // bus-side interrupt status: request rise and bus error
    assign req_rise      = next_periph_irq && !periph_irq;
    assign bus_err_event = done && !mapped;

    always_comb
    begin
        irq_set                  = '0;
        irq_set[PIF_IRQ_REQ]     = req_rise;
        irq_set[PIF_IRQ_BUS_ERR] = bus_err_event;
    end

    pif_flag_bank #(
        .WIDTH      (PIF_IRQ_W),
        .WRITE_MASK (PIF_IRQ_ALL),
        .ONE_CLEARS (1'b1)
    ) u_irq_status (
        .clk     (clk),
        .sys_rst (sys_rst),
        .set_vec (irq_set),
        .wr_en   (wr_done && hit_irq_status),
        .wr_data (pwdata[PIF_IRQ_W-1:0]),
        .flags   (irq_status)
    );

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            irq_mask <= '0;
        else if (wr_done && hit_irq_mask)
            irq_mask <= pwdata[PIF_IRQ_W-1:0];
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            irq <= 1'b0;
        else
            irq <= |(irq_status & irq_mask);
    end

    // read selection; the transmit data register reads as zero
    assign rd_value =
          hit_flags_one  ? pif_word(peripheral_flags_one)
        : hit_flags_two  ? pif_word(peripheral_flags_two)
        : hit_en_one     ? pif_word(enable_one)
        : hit_en_two     ? pif_word(enable_two)
        : hit_core_ctrl  ? pif_word(core_interrupt_control)
        : hit_rx_data    ? pif_word(rx_data)
        : hit_irq_status ? pif_word(PIF_REG_W'(irq_status))
        : hit_irq_mask   ? pif_word(PIF_REG_W'(irq_mask))
        : '0;

    // answer: pready, data and error all come from flops
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            pready  <= 1'b0;
            prdata  <= '0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= next_pready;
            pslverr <= next_pready && !mapped;
            if (next_pready)
                prdata <= pwrite ? '0 : rd_value;
        end
    end

endmodule : pif_peripheral_flags

// ==== core/pif_pkg.sv ====
// package: register map, field layout and codes of the peripheral flags
package pif_pkg;

    localparam int unsigned PIF_DATA_W = 32;
    localparam int unsigned PIF_REG_W  = 8;
    localparam int unsigned PIF_ADDR_W = 8;

    // register byte addresses
    localparam logic [7:0] PIF_OFF_FLAGS_ONE  = 8'h00;
    localparam logic [7:0] PIF_OFF_FLAGS_TWO  = 8'h04;
    localparam logic [7:0] PIF_OFF_EN_ONE     = 8'h08;
    localparam logic [7:0] PIF_OFF_EN_TWO     = 8'h0c;
    localparam logic [7:0] PIF_OFF_CORE_CTRL  = 8'h10;
    localparam logic [7:0] PIF_OFF_RX_DATA    = 8'h14;
    localparam logic [7:0] PIF_OFF_TX_DATA    = 8'h18;
    localparam logic [7:0] PIF_OFF_IRQ_STATUS = 8'h1c;
    localparam logic [7:0] PIF_OFF_IRQ_MASK   = 8'h20;

    // first flag register
    localparam int unsigned PIF_BIT_ADC  = 6;
    localparam int unsigned PIF_BIT_RX   = 5;
    localparam int unsigned PIF_BIT_TX   = 4;
    localparam int unsigned PIF_BIT_SSP  = 3;
    localparam int unsigned PIF_BIT_CCP  = 2;
    localparam int unsigned PIF_BIT_PRD  = 1;
    localparam int unsigned PIF_BIT_OVF  = 0;

    // second flag register
    localparam int unsigned PIF_BIT_OSC  = 7;
    localparam int unsigned PIF_BIT_CMP2 = 6;
    localparam int unsigned PIF_BIT_CMP1 = 5;
    localparam int unsigned PIF_BIT_NVW  = 4;

    // core interrupt control
    localparam int unsigned PIF_BIT_PER_EN = 6;

    // implemented and writable bits
    localparam logic [7:0] PIF_IMPL_ONE  = 8'h7f;
    localparam logic [7:0] PIF_WR_ONE    = 8'h4f;
    localparam logic [7:0] PIF_IMPL_TWO  = 8'hf0;
    localparam logic [7:0] PIF_CTRL_MASK = 8'h40;
    localparam logic [7:0] PIF_RST_REG   = 8'h00;

    // capture/compare modes
    localparam logic [1:0] PIF_CCP_OFF     = 2'h0;
    localparam logic [1:0] PIF_CCP_CAPTURE = 2'h1;
    localparam logic [1:0] PIF_CCP_COMPARE = 2'h2;
    localparam logic [1:0] PIF_CCP_PWM     = 2'h3;

    // bus-side interrupt status
    localparam int unsigned PIF_IRQ_W       = 2;
    localparam int unsigned PIF_IRQ_REQ     = 0;
    localparam int unsigned PIF_IRQ_BUS_ERR = 1;
    localparam logic [1:0]  PIF_IRQ_ALL     = 2'h3;

endpackage : pif_pkg
